// [bench/trhg_reader.sv]
`timescale 1ns/100ps
`default_nettype none
module trhg_reader
(
  input  wire logic clk_sys_in,
  input  wire logic valid_in,
  input  wire logic go_in,
  output logic      read_out,
  output int        count_out
);
  initial read_out = 1'b0;
  initial count_out = 0;
  always @(negedge clk_sys_in)
  begin
    read_out <= go_in && valid_in && !read_out;
    if (read_out)
      count_out <= count_out + 1;
  end
endmodule // trhg_reader
`default_nettype wire

// [bench/trhg_top_props.sv]
`timescale 1ns/100ps
`default_nettype none
module trhg_top_props
  import trhg_pkg::*;
#(
  parameter int WORD_WIDTH = trhg_pkg::WORD_W
)
(
  input wire logic                  clk_sys_in,
  input wire logic                  reset_in,
  input wire logic                  retest_in,
  input wire logic                  shutdown_in,
  input wire logic                  read_in,
  input wire logic [WORD_WIDTH-1:0] rnd_word_out,
  input wire logic                  rnd_valid_out,
  input wire logic                  ready_out,
  input wire logic                  fail_out,
  input wire logic                  shut_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  property p_gate; rnd_valid_out |-> ready_out; endproperty
  a_gate: assert property (p_gate) else $error("valid outside run");
  property p_fail; fail_out |-> !rnd_valid_out; endproperty
  a_fail: assert property (p_fail) else $error("valid in fault");
  property p_shut; shut_out |-> !rnd_valid_out; endproperty
  a_shut: assert property (p_shut) else $error("valid when shut");
  property p_fst; fail_out |=> fail_out || shut_out; endproperty
  a_fst: assert property (p_fst) else $error("fault cleared");
  property p_shdn; shutdown_in |=> shut_out; endproperty
  a_shdn: assert property (p_shdn) else $error("no shut");
  property p_rtst; ready_out && retest_in |=> !ready_out; endproperty
  a_rtst: assert property (p_rtst) else $error("retest ignored");
  property p_hold;
    rnd_valid_out && !read_in |=> rnd_valid_out || !ready_out;
  endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_stab;
    rnd_valid_out && !read_in ##1 rnd_valid_out |-> $stable(rnd_word_out);
  endproperty
  a_stab: assert property (p_stab) else $error("word changed");
  c_read: cover property (rnd_valid_out && read_in);
  c_fail: cover property ($rose(fail_out));
  c_shut: cover property ($rose(shut_out));
endmodule // trhg_top_props
bind trhg_top trhg_top_props #(.WORD_WIDTH(WORD_WIDTH)) trhg_props_inst (.*);
`default_nettype wire

// [bench/trhg_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module trhg_top_tb;
  import trhg_pkg::*;
  logic clk_sys_in, reset_in, enable_in, retest_in, shutdown_in, go;
  logic raw_valid_in, raw_bit_in, read_in, rnd_valid_out;
  logic ready_out, fail_out, shut_out;
  logic [WORD_W-1:0] rnd_word_out;
  int err_count, n_checks, count, c0;
  trhg_top trhg_top_inst (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .enable_in(enable_in), .retest_in(retest_in),
    .shutdown_in(shutdown_in), .raw_valid_in(raw_valid_in),
    .raw_bit_in(raw_bit_in), .read_in(read_in),
    .rnd_word_out(rnd_word_out), .rnd_valid_out(rnd_valid_out),
    .ready_out(ready_out), .fail_out(fail_out), .shut_out(shut_out));
  trhg_reader trhg_reader_inst (.clk_sys_in(clk_sys_in),
    .valid_in(rnd_valid_out), .go_in(go), .read_out(read_in),
    .count_out(count));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic feed(input int n, input logic stuck);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_sys_in);
      raw_valid_in = 1'b1;
      raw_bit_in = stuck | i[1];
    end
    @(negedge clk_sys_in);
    raw_valid_in = 1'b0;
  endtask
  task automatic rst;
    reset_in = 1'b1;
    enable_in = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    reset_in = 1'b0;
    enable_in = 1'b1;
  endtask
  task automatic up;
    rst;
    feed(512, 1'b0);
    chk("early", ready_out, 16'h0);
    feed(512, 1'b0);
    repeat (2) @(negedge clk_sys_in);
    chk("ready", ready_out, 16'h1);
    $display("startup done");
  endtask
  task automatic t_word;
    go = 1'b0;
    feed(64, 1'b0);
    @(negedge clk_sys_in);
    chk("valid", rnd_valid_out, 16'h1);
    chk("width", $bits(rnd_word_out), 16'h10);
    go <= 1'b1;
    repeat (4) @(negedge clk_sys_in);
    chk("read", rnd_valid_out, 16'h0);
    chk("words", count, 16'h1);
    $display("word done");
  endtask
  task automatic t_retest;
    retest_in = 1'b1;
    @(negedge clk_sys_in);
    retest_in = 1'b0;
    chk("retest", ready_out, 16'h0);
    feed(1024, 1'b0);
    repeat (2) @(negedge clk_sys_in);
    chk("rerun", ready_out, 16'h1);
    $display("retest done");
  endtask
  task automatic t_shut;
    shutdown_in = 1'b1;
    @(negedge clk_sys_in);
    shutdown_in = 1'b0;
    feed(70, 1'b0);
    chk("shut", shut_out, 16'h1);
    chk("shutvalid", rnd_valid_out, 16'h0);
    chk("shutword", rnd_word_out, 16'h0);
    $display("shut done");
  endtask
  task automatic t_fail;
    up;
    c0 = count;
    feed(80, 1'b1);
    chk("fail", fail_out, 16'h1);
    chk("nowords", count, c0[15:0]);
    rst;
    feed(80, 1'b1);
    chk("deadfail", fail_out, 16'h1);
    chk("deadready", ready_out, 16'h0);
    chk("deadvalid", rnd_valid_out, 16'h0);
    $display("fail done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    err_count = 0;
    n_checks = 0;
    go = 1'b0;
    retest_in = 1'b0;
    shutdown_in = 1'b0;
    raw_valid_in = 1'b0;
    raw_bit_in = 1'b0;
    up;
    t_word;
    t_retest;
    t_shut;
    t_fail;
    wrap_up;
  end
endmodule // trhg_top_tb
`default_nettype wire

// [src/trhg_health.sv]
`timescale 1ns/100ps
`default_nettype none
module trhg_health
  import trhg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  // Restart and raw bit stream
  input  wire logic restart_in,
  input  wire logic raw_valid_in,
  input  wire logic raw_bit_in,
  // Results
  output logic      total_fail_out,
  output logic      win_done_out,
  output logic      win_pass_out
);
  logic [STUCK_W-1:0] stuck_reg;
  logic [RUN_W-1:0]   run_reg;
  logic [WIN_W-1:0]   cnt_reg;
  logic [WIN_W:0]     ones_reg;
  logic               last_reg;
  logic               run_bad_reg;
  logic               tf_reg;
  logic               done_reg;
  logic               pass_reg;

  wire same_bit = raw_bit_in == last_reg;
  wire win_last = cnt_reg == WIN_W'(WIN_LEN - 1);
  wire [WIN_W:0] ones_fin = ones_reg + (WIN_W+1)'(raw_bit_in);
  wire run_hit = same_bit && run_reg == RUN_W'(RUN_MAX - 1);
  wire ones_ok = ones_fin >= (WIN_W+1)'(ONES_LO)
               && ones_fin <= (WIN_W+1)'(ONES_HI);

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      stuck_reg   <= '0;
      run_reg     <= '0;
      cnt_reg     <= '0;
      ones_reg    <= '0;
      last_reg    <= 1'b0;
      run_bad_reg <= 1'b0;
      tf_reg      <= 1'b0;
      done_reg    <= 1'b0;
      pass_reg    <= 1'b0;
    end
    else if (restart_in)
    begin
      stuck_reg   <= '0;
      run_reg     <= '0;
      cnt_reg     <= '0;
      ones_reg    <= '0;
      run_bad_reg <= 1'b0;
      tf_reg      <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (raw_valid_in)
      begin
        last_reg  <= raw_bit_in;
        // Stuck source: total failure
        stuck_reg <= same_bit ? stuck_reg + STUCK_W'(1) : '0;
        if (same_bit && stuck_reg == STUCK_W'(STUCK_MAX - 2))
          tf_reg <= 1'b1;
        run_reg <= same_bit ? run_reg + RUN_W'(1) : '0;
        cnt_reg <= cnt_reg + WIN_W'(1);
        if (win_last)
        begin
          // Window verdict: bias and run length
          done_reg    <= 1'b1;
          pass_reg    <= ones_ok && !run_bad_reg && !run_hit;
          ones_reg    <= '0;
          run_bad_reg <= 1'b0;
        end
        else
        begin
          ones_reg <= ones_fin;
          if (run_hit)
            run_bad_reg <= 1'b1;
        end
      end
    end
  end

  assign total_fail_out = tf_reg;
  assign win_done_out   = done_reg;
  assign win_pass_out   = pass_reg;
endmodule // trhg_health
`default_nettype wire

// [src/trhg_pkg.sv]
package trhg_pkg;
  localparam int WORD_W       = 16;
  localparam int WIN_W        = 10;
  localparam int WIN_LEN      = 1024;
  localparam int ONES_LO      = 410;
  localparam int ONES_HI      = 614;
  localparam int RUN_MAX      = 34;
  localparam int RUN_W        = 6;
  localparam int STUCK_MAX    = 64;
  localparam int STUCK_W      = 7;
  localparam int POOL_W       = 16;
  localparam int MIX_BITS     = 4;
  localparam logic [15:0] POOL_RST = 16'h0000;

  typedef enum logic [2:0] {
    TRHG_IDLE,
    TRHG_STARTUP,
    TRHG_RUN,
    TRHG_RETEST,
    TRHG_FAULT,
    TRHG_SHUT
  } trhg_state_t;
endpackage

// [src/trhg_top.sv]
`timescale 1ns/100ps
`default_nettype none
module trhg_top
  import trhg_pkg::*;
#(
  parameter int WORD_WIDTH = trhg_pkg::WORD_W
)
(
  // Clock and reset
  input  wire logic                  clk_sys_in,
  input  wire logic                  reset_in,
  // Control
  input  wire logic                  enable_in,
  input  wire logic                  retest_in,
  input  wire logic                  shutdown_in,
  // Entropy source
  input  wire logic                  raw_valid_in,
  input  wire logic                  raw_bit_in,
  // Consumer
  input  wire logic                  read_in,
  output logic [WORD_WIDTH-1:0]      rnd_word_out,
  output logic                       rnd_valid_out,
  // Status
  output logic                       ready_out,
  output logic                       fail_out,
  output logic                       shut_out
);
  import trhg_pkg::*;

  trhg_state_t             state_reg;
  trhg_state_t             state_next;
  logic [POOL_W-1:0]       pool_reg;
  logic [$clog2(WORD_WIDTH*MIX_BITS+1)-1:0] fill_reg;
  logic [WORD_WIDTH-1:0]   word_reg;
  logic                    word_vld_reg;

  logic total_fail;
  logic win_done;
  logic win_pass;

  localparam int FILL_W = $clog2(WORD_WIDTH*MIX_BITS+1);
  localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(WORD_WIDTH*MIX_BITS);

  wire restart   = (state_reg == TRHG_IDLE && enable_in)
                 || (state_reg == TRHG_RUN && retest_in);
  wire running   = state_reg == TRHG_RUN;
  wire gated     = !running || total_fail;
  wire pool_full = fill_reg == FILL_FULL;
  wire fb_bit    = pool_reg[POOL_W-1] ^ pool_reg[4] ^ pool_reg[2]
                 ^ pool_reg[1] ^ raw_bit_in;

  trhg_health trhg_health_inst (
    .clk_sys_in     (clk_sys_in),
    .reset_in       (reset_in),
    .restart_in     (restart),
    .raw_valid_in   (raw_valid_in),
    .raw_bit_in     (raw_bit_in),
    .total_fail_out (total_fail),
    .win_done_out   (win_done),
    .win_pass_out   (win_pass)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TRHG_IDLE:
        if (enable_in)
          state_next = TRHG_STARTUP;
      TRHG_STARTUP:
        if (total_fail)
          state_next = TRHG_FAULT;
        else if (win_done)
          state_next = win_pass ? TRHG_RUN : TRHG_FAULT;
      TRHG_RUN:
        if (total_fail || (win_done && !win_pass))
          state_next = TRHG_FAULT;
        else if (retest_in)
          state_next = TRHG_RETEST;
      TRHG_RETEST:
        if (total_fail)
          state_next = TRHG_FAULT;
        else if (win_done)
          state_next = win_pass ? TRHG_RUN : TRHG_FAULT;
      TRHG_FAULT:
        state_next = TRHG_FAULT;
      TRHG_SHUT:
        state_next = TRHG_SHUT;
      default:
        state_next = TRHG_FAULT;
    endcase
    if (shutdown_in)
      state_next = TRHG_SHUT;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
      state_reg <= TRHG_IDLE;
    else
      state_reg <= state_next;
  end

  // Conditioning pool, several raw bits per output bit
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pool_reg <= POOL_RST;
      fill_reg <= '0;
    end
    else if (gated || restart)
    begin
      fill_reg <= '0;
    end
    else if (raw_valid_in && !pool_full)
    begin
      pool_reg <= {pool_reg[POOL_W-2:0], fb_bit};
      fill_reg <= fill_reg + FILL_W'(1);
    end
    else if (pool_full && (!word_vld_reg || read_in))
    begin
      fill_reg <= '0;
    end
  end

  // Output word holding register
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      word_reg     <= '0;
      word_vld_reg <= 1'b0;
    end
    else if (gated)
    begin
      word_reg     <= '0;
      word_vld_reg <= 1'b0;
    end
    else if (pool_full && (!word_vld_reg || read_in))
    begin
      word_reg     <= pool_reg[WORD_WIDTH-1:0];
      word_vld_reg <= 1'b1;
    end
    else if (read_in)
    begin
      word_vld_reg <= 1'b0;
    end
  end

  assign rnd_word_out  = word_reg;
  assign rnd_valid_out = word_vld_reg && !gated;
  assign ready_out     = running;
  assign fail_out      = state_reg == TRHG_FAULT;
  assign shut_out      = state_reg == TRHG_SHUT;
endmodule // trhg_top
`default_nettype wire
